//--- hw/rtc_ctrl_pkg.sv
// Constants for the clock/calendar control, flag and battery-status block.
// Assumes a 40 MHz system clock and a one-cycle tick per 32.768 kHz period.
package rtc_ctrl_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int DIV_W = 15;

  // Register offsets on the multiplexed bus
  localparam logic [6:0] OFS_RATE = 7'h0A;
  localparam logic [6:0] OFS_CTRL = 7'h0B;
  localparam logic [6:0] OFS_FLAGS = 7'h0C;
  localparam logic [6:0] OFS_BATT = 7'h0D;

  // Field positions of the control word
  localparam int CTRL_SET_BIT = 7;
  localparam int CTRL_PIE_BIT = 6;
  localparam int CTRL_AIE_BIT = 5;
  localparam int CTRL_UIE_BIT = 4;
  localparam int CTRL_SQUARE_OUT_EN_BIT = 3;
  localparam int CTRL_DM_BIT = 2;
  localparam int CTRL_H24_BIT = 1;
  localparam int CTRL_DSE_BIT = 0;

  // Field positions of the flag, battery and rate registers
  localparam int FLAG_IRQ_BIT = 7;
  localparam int FLAG_PF_BIT = 6;
  localparam int FLAG_AF_BIT = 5;
  localparam int FLAG_UF_BIT = 4;
  localparam int BATT_OK_BIT = 7;
  localparam int RATE_UIP_BIT = 7;

  // Values after system reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] RATE_RESET = 4'h0;

  // Lead of the update-in-progress window before the second boundary
  localparam int TIMEBASE_HZ = 32768;
  localparam int UIP_LEAD_US = 244;
  localparam int UIP_LEAD_TICKS = (UIP_LEAD_US * TIMEBASE_HZ + 999999) / 1000000;
  localparam logic [14:0] UIP_START_COUNT = 15'(TIMEBASE_HZ - UIP_LEAD_TICKS);

  // Calendar values for the seasonal updates and the alarm match-all code
  localparam logic [7:0] SUNDAY = 8'h01;
  localparam logic [7:0] APRIL = 8'h04;
  localparam int OCTOBER = 10;
  localparam int LAST_WEEK_FIRST_DATE = 25;
  localparam int FIRST_WEEK_LAST_DATE = 7;
  localparam logic [7:0] HOUR_ONE_AM = 8'h01;
  localparam int MINUTE_LAST = 59;
  localparam int SECOND_LAST = 59;
  localparam logic [1:0] ALARM_ANY = 2'b11;

endpackage : rtc_ctrl_pkg

//--- hw/rtc_control_status_irq.sv
// Control word, interrupt flags, battery status and interrupt request of a
// clock/calendar device, on a multiplexed address/data bus.
// Assumes all inputs synchronous to clk_sys; time counters live outside.
// Summary of operation
// (RULE1) Freeze bit set blocks update transfers; clear lets counts advance each second.
// (RULE2) Freeze bit is host read/write; reset input and internal functions leave it.
// (RULE3) Periodic enable only gates periodic flag to interrupt; flag sets regardless.
// (RULE4) Reset input clears periodic enable; nothing internal alters it.
// (RULE5) Alarm fires each second time bytes match alarm bytes; top bits 11 match all.
// (RULE6) Reset input clears alarm enable; internal functions leave it.
// (RULE7) Update-ended enable cleared by reset input and when freeze bit rises.
// (RULE8) Square-wave enable drives selected rate on pin, else low; reset clears it.
// (RULE9) Data-format bit: one binary, zero BCD; host-writable, reset leaves it.
// (RULE10) Hour-format bit: one 24-hour, zero 12-hour; reset leaves it.
// (RULE11) Daylight saving: first Sunday April, 1:59:59 AM steps to 3:00:00 AM.
// (RULE12) Daylight saving: last Sunday October, 1:59:59 AM returns to 1:00:00 AM.
// (RULE13) Daylight saving off stops both special updates; reset leaves the enable.
// (RULE14) Summary flag bit 7 is OR of each flag ANDed with its enable.
// (RULE15) Interrupt request driven low while summary flag is one.
// (RULE16) Reading flag register or reset input low clears every flag.
// (RULE17) Periodic flag bit 6 sets on each rising edge of the selected divider tap.
// (RULE18) Alarm flag bit 5 sets on time match; cleared by read or reset.
// (RULE19) Update-ended flag bit 4 sets after each update cycle; read or reset clears.
// (RULE20) Flag register bits 3..0 read zero and ignore writes.
// (RULE21) Battery register bit 7 read-only, one when battery good; reset leaves it.
// (RULE22) Battery register bits 6..0 read zero and ignore writes.
// (RULE23) Flag register latched during a read; new events held until read ends.
// (RULE24) Writing freeze bit one also clears update-in-progress status.
// (RULE25) Interrupt request is open drain: pulls low or floats.
// (RULE26) Interrupt request releases in the cycle the summary flag falls.
// (RULE27) Host must examine all set flags on each flag register read.
`timescale 1ns/100ps

module rtc_control_status_irq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_n,
  // Multiplexed address/data bus
  input wire logic cs_n,
  input wire logic addr_strobe,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [rtc_ctrl_pkg::DATA_W-1:0] ad_in,
  output logic [rtc_ctrl_pkg::DATA_W-1:0] ad_out,
  output logic ad_oe_n,
  // Time base and battery
  input wire logic timebase_tick,
  input wire logic battery_ok,
  // Current user time and calendar, alarm bytes
  input wire logic [7:0] time_sec,
  input wire logic [7:0] time_min,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] day_of_week,
  input wire logic [7:0] day_of_month,
  input wire logic [7:0] month,
  input wire logic [7:0] alarm_sec,
  input wire logic [7:0] alarm_min,
  input wire logic [7:0] alarm_hour,
  // Controls to the time counters
  output logic update_transfer,
  output logic dst_spring_forward,
  output logic dst_fall_back,
  output logic data_format_binary,
  output logic hour_24,
  // Square wave and interrupt request pins
  output logic square_out,
  output logic irq_out,
  output logic irq_oe_n
);
  import rtc_ctrl_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr_act;
    logic [DATA_W-1:0] wdata;
    logic rd_act;
    logic rd_flags;
    logic set_freeze;
    logic periodic_irq_en;
    logic alarm_irq_en;
    logic update_done_irq_en;
    logic square_out_en;
    logic data_format_binary;
    logic hour_24;
    logic daylight_saving_en;
    logic [3:0] rate_select;
    logic update_in_progress;
    logic [DIV_W-1:0] div;
    logic tap_prev;
    logic periodic_flag;
    logic alarm_flag;
    logic update_done_flag;
    logic [2:0] pend;
    logic [DATA_W-1:0] ad_out;
    logic ad_oe_n;
    logic irq_oe_n;
    logic square_out;
    logic update_transfer;
    logic dst_spring;
    logic dst_fall;
  } state_type;

  state_type s_reg;
  state_type s_next;

  // Encode a decimal constant in the selected data format
  function automatic logic [7:0] fmt(input int value, input logic binary);
    logic [7:0] v;
    v = 8'(value);
    if (binary) begin
      fmt = v;
    end else begin
      fmt = {4'(value / 10), 4'(value % 10)};
    end
  endfunction : fmt

  function automatic logic alarm_byte_match(input logic [7:0] t, input logic [7:0] a);
    alarm_byte_match = (a[7:6] == ALARM_ANY) || (t == a);
  endfunction : alarm_byte_match

  // Divider tap for a rate code; codes 1 and 2 reuse the taps of 8 and 9
  function automatic logic tap_of(input logic [3:0] rs, input logic [DIV_W-1:0] d);
    logic [3:0] r;
    r = rs;
    if (rs == 4'h1) begin
      r = 4'h8;
    end else if (rs == 4'h2) begin
      r = 4'h9;
    end
    if (rs == 4'h0) begin
      tap_of = 1'b0;
    end else begin
      tap_of = d[r - 4'h2];
    end
  endfunction : tap_of

  logic tap_now;
  logic second_wrap;
  logic at_one_59_59;
  logic pf_ev;
  logic af_ev;
  logic uf_ev;
  logic rd_start;
  logic rd_end;
  logic wr_end;
  logic summary;
  logic [DATA_W-1:0] rd_value;

  always_comb begin
    s_next = s_reg;
    tap_now = tap_of(s_reg.rate_select, s_reg.div);
    second_wrap = timebase_tick && (s_reg.div == {DIV_W{1'b1}});
    rd_start = !rd_n && !cs_n && !s_reg.rd_act;
    rd_end = s_reg.rd_act && rd_n;
    wr_end = s_reg.wr_act && wr_n;
    rd_value = 8'h00;

    // Address latch while the strobe is high
    if (addr_strobe) begin
      s_next.addr = ad_in[ADDR_W-1:0];
    end

    // Divider, square wave and periodic edge
    if (timebase_tick) begin
      s_next.div = s_reg.div + 15'h0001;
    end
    s_next.tap_prev = tap_now;
    pf_ev = tap_now && !s_reg.tap_prev; // RULE17 RULE3
    s_next.square_out = s_reg.square_out_en && tap_now; // RULE8

    // Update cycle window opens each second only while the freeze bit is clear
    if (timebase_tick && s_reg.div == UIP_START_COUNT - 15'h0001 && !s_reg.set_freeze) begin
      s_next.update_in_progress = 1'b1;
    end
    if (second_wrap) begin
      s_next.update_in_progress = 1'b0;
    end
    s_next.update_transfer = second_wrap && !s_reg.set_freeze; // RULE1
    uf_ev = second_wrap; // RULE19
    af_ev = second_wrap && alarm_byte_match(time_sec, alarm_sec)
      && alarm_byte_match(time_min, alarm_min)
      && alarm_byte_match(time_hour, alarm_hour); // RULE5 RULE18

    // Seasonal updates; 1 AM reads the same in every hour and data format
    at_one_59_59 = (time_hour == HOUR_ONE_AM)
      && (time_min == fmt(MINUTE_LAST, s_reg.data_format_binary))
      && (time_sec == fmt(SECOND_LAST, s_reg.data_format_binary));
    s_next.dst_spring = s_reg.daylight_saving_en && second_wrap && !s_reg.set_freeze
      && at_one_59_59 && month == APRIL && day_of_week == SUNDAY
      && day_of_month <= fmt(FIRST_WEEK_LAST_DATE, s_reg.data_format_binary); // RULE11 RULE13
    s_next.dst_fall = s_reg.daylight_saving_en && second_wrap && !s_reg.set_freeze
      && at_one_59_59 && month == fmt(OCTOBER, s_reg.data_format_binary)
      && day_of_week == SUNDAY
      && day_of_month >= fmt(LAST_WEEK_FIRST_DATE, s_reg.data_format_binary); // RULE12 RULE13

    // Register read data, snapshot at the start of the read
    if (s_reg.addr == OFS_RATE) begin
      rd_value = {s_reg.update_in_progress, 3'b000, s_reg.rate_select};
    end else if (s_reg.addr == OFS_CTRL) begin
      rd_value = {s_reg.set_freeze, s_reg.periodic_irq_en, s_reg.alarm_irq_en,
        s_reg.update_done_irq_en, s_reg.square_out_en, s_reg.data_format_binary,
        s_reg.hour_24, s_reg.daylight_saving_en};
    end else if (s_reg.addr == OFS_FLAGS) begin
      rd_value = {!s_reg.irq_oe_n, s_reg.periodic_flag, s_reg.alarm_flag,
        s_reg.update_done_flag, 4'h0}; // RULE20
    end else if (s_reg.addr == OFS_BATT) begin
      rd_value = {battery_ok, 7'h00}; // RULE21 RULE22
    end

    if (rd_start) begin
      s_next.rd_act = 1'b1;
      s_next.ad_out = rd_value; // RULE23
      s_next.rd_flags = (s_reg.addr == OFS_FLAGS);
      // Events of the snapshot cycle miss the snapshot; hold them too
      if (s_reg.addr == OFS_FLAGS) begin
        s_next.pend = {pf_ev, af_ev, uf_ev}; // RULE23
      end
      // Unmapped addresses leave the bus floating
      s_next.ad_oe_n = !(s_reg.addr >= OFS_RATE && s_reg.addr <= OFS_BATT);
    end
    if (rd_end) begin
      s_next.rd_act = 1'b0;
      s_next.rd_flags = 1'b0;
      s_next.ad_oe_n = 1'b1;
    end

    // Flags: held aside while the flag register is being read
    if (s_reg.rd_flags) begin
      s_next.pend = s_reg.pend | {pf_ev, af_ev, uf_ev}; // RULE23
      if (rd_end) begin
        {s_next.periodic_flag, s_next.alarm_flag, s_next.update_done_flag} =
          s_next.pend; // RULE16
        s_next.pend = 3'b000;
      end
    end else begin
      s_next.periodic_flag = s_reg.periodic_flag || pf_ev;
      s_next.alarm_flag = s_reg.alarm_flag || af_ev;
      s_next.update_done_flag = s_reg.update_done_flag || uf_ev;
    end

    // Writes commit on the trailing edge of the write strobe
    if (!wr_n && !cs_n) begin
      s_next.wr_act = 1'b1;
      s_next.wdata = ad_in;
    end
    if (wr_end) begin
      s_next.wr_act = 1'b0;
      if (s_reg.addr == OFS_RATE) begin
        s_next.rate_select = s_reg.wdata[3:0];
      end else if (s_reg.addr == OFS_CTRL) begin
        s_next.set_freeze = s_reg.wdata[CTRL_SET_BIT]; // RULE2
        s_next.periodic_irq_en = s_reg.wdata[CTRL_PIE_BIT];
        s_next.alarm_irq_en = s_reg.wdata[CTRL_AIE_BIT];
        s_next.update_done_irq_en = s_reg.wdata[CTRL_UIE_BIT];
        s_next.square_out_en = s_reg.wdata[CTRL_SQUARE_OUT_EN_BIT];
        s_next.data_format_binary = s_reg.wdata[CTRL_DM_BIT]; // RULE9
        s_next.hour_24 = s_reg.wdata[CTRL_H24_BIT]; // RULE10
        s_next.daylight_saving_en = s_reg.wdata[CTRL_DSE_BIT];
        if (s_reg.wdata[CTRL_SET_BIT]) begin
          s_next.update_in_progress = 1'b0; // RULE24
          s_next.update_transfer = 1'b0; // RULE1
          if (!s_reg.set_freeze) begin
            s_next.update_done_irq_en = 1'b0; // RULE7
          end
        end
      end
      // Flag and battery registers ignore writes
    end

    // Reset input: interrupt and square-wave enables, square output and flags only
    if (!reset_n) begin
      s_next.periodic_irq_en = 1'b0; // RULE4
      s_next.alarm_irq_en = 1'b0; // RULE6
      s_next.update_done_irq_en = 1'b0; // RULE7
      s_next.square_out_en = 1'b0; // RULE8
      s_next.square_out = 1'b0;
      s_next.periodic_flag = 1'b0; // RULE16
      s_next.alarm_flag = 1'b0;
      s_next.update_done_flag = 1'b0;
      s_next.pend = 3'b000;
    end

    // Registered from next state so release follows the flag fall at once
    summary = (s_next.periodic_flag && s_next.periodic_irq_en)
      || (s_next.alarm_flag && s_next.alarm_irq_en)
      || (s_next.update_done_flag && s_next.update_done_irq_en); // RULE14 RULE3
    s_next.irq_oe_n = !summary; // RULE15 RULE25 RULE26
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.set_freeze <= CTRL_RESET[CTRL_SET_BIT];
      s_reg.rate_select <= RATE_RESET;
      s_reg.ad_oe_n <= 1'b1;
      s_reg.irq_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ad_out = s_reg.ad_out;
  assign ad_oe_n = s_reg.ad_oe_n;
  assign update_transfer = s_reg.update_transfer;
  assign dst_spring_forward = s_reg.dst_spring;
  assign dst_fall_back = s_reg.dst_fall;
  assign data_format_binary = s_reg.data_format_binary;
  assign hour_24 = s_reg.hour_24;
  assign square_out = s_reg.square_out;
  // Open drain: pin level is always low, only the enable moves
  assign irq_out = 1'b0; // RULE25
  assign irq_oe_n = s_reg.irq_oe_n;

endmodule : rtc_control_status_irq

//--- tb/host_bus_model.sv
// Host processor model driving the multiplexed address/data bus.
// Assumes the device answers a read on the same edge that takes it.
`timescale 1ns/100ps
module host_bus_model (
  // Clock
  input wire logic clk_sys,
  // Multiplexed bus
  output logic cs_n,
  output logic addr_strobe,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] ad_in,
  input wire logic [7:0] ad_out,
  input wire logic ad_oe_n
);
  initial begin
    cs_n = 1'b1;
    addr_strobe = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    ad_in = 8'h00;
  end
  task automatic put_addr(input logic [6:0] a);
    @(negedge clk_sys);
    addr_strobe = 1'b1;
    ad_in = {1'b0, a};
    @(negedge clk_sys);
    addr_strobe = 1'b0;
  endtask : put_addr
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    put_addr(a);
    cs_n = 1'b0;
    wr_n = 1'b0;
    ad_in = d;
    @(negedge clk_sys);
    cs_n = 1'b1;
    wr_n = 1'b1;
    // Released bus shows the inverse, never stale data
    ad_in = ~d;
  endtask : write_reg
  // Caller must examine every returned flag bit
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic oe);
    put_addr(a);
    cs_n = 1'b0;
    rd_n = 1'b0;
    ad_in = ~ad_in;
    // Answer stands from the taking edge until rd_n is seen high
    @(negedge clk_sys);
    oe = ~ad_oe_n;
    d = ad_out;
    cs_n = 1'b1;
    rd_n = 1'b1;
    // Let the read end before the caller looks at the pins
    @(negedge clk_sys);
  endtask : read_reg
endmodule : host_bus_model

//--- tb/rtc_control_status_irq_monitor.sv
// Assertion monitor on the ports of the control, flag and battery-status block.
// Assumes one clock domain with the synchronous active-high system reset.
`timescale 1ns/100ps
module rtc_control_status_irq_monitor (
  // Clock, reset and bus
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic addr_strobe,
  input wire logic rd_n,
  input wire logic [rtc_ctrl_pkg::DATA_W-1:0] ad_in,
  input wire logic [rtc_ctrl_pkg::DATA_W-1:0] ad_out,
  input wire logic ad_oe_n,
  // Status and pins
  input wire logic battery_ok,
  input wire logic update_transfer,
  input wire logic square_out,
  input wire logic irq_out,
  input wire logic irq_oe_n
);
  import rtc_ctrl_pkg::*;
  logic [6:0] addr_reg;
  logic [6:0] addr_next;
  always_comb addr_next = addr_strobe ? ad_in[6:0] : addr_reg;
  always_ff @(posedge clk_sys) addr_reg <= addr_next;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence rd_start;
    $fell(rd_n) && !cs_n;
  endsequence
  a_irq_open_drain: assert property (irq_out == 1'b0)
    else $error("irq data line not low");
  a_reset_irq_release: assert property (!reset_n |=> irq_oe_n)
    else $error("irq still pulled after reset input");
  a_reset_square_low: assert property (!reset_n |=> !square_out)
    else $error("square output high after reset input");
  a_transfer_once: assert property (update_transfer |=> !update_transfer [*8])
    else $error("update transfer repeated");
  a_read_answer: assert property (
    rd_start ##0 (addr_reg >= OFS_RATE && addr_reg <= OFS_BATT) |=> !ad_oe_n)
    else $error("mapped read not answered");
  a_battery_value: assert property (
    rd_start ##0 (addr_reg == OFS_BATT) |=> ad_out == {battery_ok, 7'h00})
    else $error("battery byte wrong");
  a_flags_unused_zero: assert property (
    rd_start ##0 (addr_reg == OFS_FLAGS) |=> ad_out[3:0] == 4'h0)
    else $error("unused flag bits not zero");
  a_summary_irq_pin: assert property (
    rd_start ##0 (addr_reg == OFS_FLAGS) |=> ad_out[FLAG_IRQ_BIT] == !$past(irq_oe_n))
    else $error("summary bit differs from irq pin");
  a_read_release: assert property (rd_n |=> ad_oe_n)
    else $error("bus driven after read ended");
  c_flags_read: cover property (rd_start ##0 (addr_reg == OFS_FLAGS));
  c_transfer: cover property (update_transfer);
  c_irq_pull: cover property ($fell(irq_oe_n));
endmodule : rtc_control_status_irq_monitor
bind rtc_control_status_irq rtc_control_status_irq_monitor mon (
  .clk_sys, .srst, .reset_n, .cs_n, .addr_strobe, .rd_n, .ad_in, .ad_out, .ad_oe_n,
  .battery_ok, .update_transfer, .square_out, .irq_out, .irq_oe_n
);

//--- tb/test_rtc_control_status_irq.sv
// Self-checking bench for the control, flag and battery-status block.
// Assumes host_bus_model drives the bus and the monitor is bound to the design.
`timescale 1ns/100ps
module test_rtc_control_status_irq;
  import rtc_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic reset_n = 1'b1;
  logic battery_ok = 1'b1;
  logic [7:0] day_of_month = 8'h05;
  logic [7:0] month = 8'h04;
  logic [7:0] day_of_week = 8'h01;
  logic [7:0] alarm_sec = 8'hC5;
  logic [7:0] alarm_min = 8'h59;
  logic [7:0] alarm_hour = 8'h01;
  logic cs_n, addr_strobe, wr_n, rd_n, ad_oe_n, oe, update_transfer, dst_spring_forward;
  logic dst_fall_back, data_format_binary, hour_24, square_out, irq_out, irq_oe_n;
  logic [7:0] ad_in, ad_out, rd;
  int fails = 0, checks = 0, cyc = 0, xfers = 0, springs = 0, falls = 0;
  initial forever #12.5 clk_sys = ~clk_sys;
  // Tick every cycle: one second is 32768 cycles
  rtc_control_status_irq dut (
    .clk_sys, .srst, .reset_n, .cs_n, .addr_strobe, .wr_n, .rd_n, .ad_in, .ad_out, .ad_oe_n,
    .timebase_tick(1'b1), .battery_ok, .time_sec(8'h59), .time_min(8'h59), .time_hour(8'h01),
    .day_of_week, .day_of_month, .month, .alarm_sec, .alarm_min, .alarm_hour,
    .update_transfer, .dst_spring_forward, .dst_fall_back,
    .data_format_binary, .hour_24, .square_out, .irq_out, .irq_oe_n
  );
  host_bus_model host (.clk_sys, .cs_n, .addr_strobe, .wr_n, .rd_n, .ad_in, .ad_out, .ad_oe_n);
  always @(posedge clk_sys) begin
    if (!srst) cyc <= cyc + 1;
    if (update_transfer === 1'b1) xfers <= xfers + 1;
    if (dst_spring_forward === 1'b1) springs <= springs + 1;
    if (dst_fall_back === 1'b1) falls <= falls + 1;
  end
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask : check_bit
  task automatic end_sim;
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic wait_until(input int n);
    while (cyc < n) @(negedge clk_sys);
  endtask : wait_until
  task automatic t_regs;
    host.read_reg(OFS_CTRL, rd, oe);
    check_byte(rd, CTRL_RESET);
    host.write_reg(OFS_BATT, 8'hFF);
    host.read_reg(OFS_BATT, rd, oe);
    check_byte(rd, 8'h80);
    battery_ok = 1'b0;
    host.read_reg(OFS_BATT, rd, oe);
    check_byte(rd, 8'h00);
    battery_ok = 1'b1;
    host.write_reg(OFS_FLAGS, 8'h0F);
    host.read_reg(OFS_FLAGS, rd, oe);
    check_byte(rd, 8'h00);
    host.read_reg(7'h20, rd, oe);
    check_bit(oe, 1'b0);
  endtask : t_regs
  task automatic t_periodic;
    int hi = 0;
    int lo = 0;
    host.write_reg(OFS_RATE, 8'h03);
    host.write_reg(OFS_CTRL, 8'h08);
    repeat (16) begin
      @(negedge clk_sys);
      hi += (square_out === 1'b1);
      lo += (square_out === 1'b0);
    end
    check_bit(hi > 0 && lo > 0, 1'b1);
    check_bit(irq_oe_n, 1'b1);
    host.read_reg(OFS_FLAGS, rd, oe);
    check_byte(rd, 8'h40);
    host.write_reg(OFS_CTRL, 8'h48);
    repeat (8) @(negedge clk_sys);
    check_bit(irq_oe_n, 1'b0);
    host.write_reg(OFS_RATE, 8'h00);
    host.read_reg(OFS_FLAGS, rd, oe);
    check_byte(rd, 8'hC0);
    check_bit(irq_oe_n, 1'b1);
    host.read_reg(OFS_FLAGS, rd, oe);
    check_byte(rd, 8'h00);
    check_bit(irq_oe_n, 1'b1);
  endtask : t_periodic
  task automatic t_reset_n;
    host.write_reg(OFS_CTRL, 8'h7F);
    @(negedge clk_sys);
    check_bit(data_format_binary, 1'b1);
    check_bit(hour_24, 1'b1);
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    host.read_reg(OFS_CTRL, rd, oe);
    check_byte(rd, 8'h07);
  endtask : t_reset_n
  task automatic t_spring;
    host.write_reg(OFS_CTRL, 8'h31);
    // Read lands inside the window before the second boundary
    wait_until(32758);
    host.read_reg(OFS_RATE, rd, oe);
    check_byte(rd, 8'h80);
    wait_until(32800);
    check_byte(8'(xfers), 8'h01);
    check_byte(8'(springs), 8'h01);
    check_bit(irq_oe_n, 1'b0);
    host.read_reg(OFS_FLAGS, rd, oe);
    check_byte(rd, 8'hB0);
  endtask : t_spring
  task automatic t_frozen;
    month = 8'h10;
    day_of_month = 8'h25;
    alarm_sec = 8'h59;
    // Freeze commits on the very edge that would raise the window flag
    wait_until(65524);
    host.write_reg(OFS_CTRL, 8'hB0);
    host.read_reg(OFS_RATE, rd, oe);
    check_byte(rd, 8'h00);
    host.read_reg(OFS_CTRL, rd, oe);
    check_byte(rd, 8'hA0);
    wait_until(65570);
    check_byte(8'(xfers + falls), 8'h01);
    host.read_reg(OFS_FLAGS, rd, oe);
    check_byte(rd, 8'hB0);
  endtask : t_frozen
  initial begin
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    t_regs();
    t_periodic();
    t_reset_n();
    t_spring();
    t_frozen();
    end_sim();
  end
  initial begin
    repeat (70000) @(posedge clk_sys);
    fails++;
    $display("wrong value at %0t: run timed out", $time);
    end_sim();
  end
endmodule : test_rtc_control_status_irq
